// *** hw/btm_pkg.sv ***
// Purpose: constants for the bit timer modulator
// Assumes: 8-bit processor register port, byte addresses
// Notes:   shared by the timer top and its fifo
package btm_pkg;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h20;
    localparam logic [7:0] ADDR_CONTROL   = 8'h21;
    localparam logic [7:0] RESET_COUNT    = 8'h00;
    localparam logic [7:0] RESET_CONTROL  = 8'h00;
    localparam int CNT_W       = 10;
    localparam int BIT_CHI     = 7;
    localparam int BIT_CLO     = 6;
    localparam int BIT_MODE_HI = 5;
    localparam int BIT_MODE_LO = 4;
    localparam int BIT_IE      = 3;
    localparam int BIT_F2      = 2;
    localparam int BIT_DATA    = 1;
    localparam int BIT_F0      = 0;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_GEN = 2'h1;
    localparam logic [1:0] MODE_RX  = 2'h2;
    localparam logic [1:0] MODE_TX  = 2'h3;
    // divide select: 11 -> /16, 10 -> /32, 01 -> /64, 00 -> /128
    localparam logic [6:0] DIV16_M1  = 7'h0F;
    localparam logic [6:0] DIV32_M1  = 7'h1F;
    localparam logic [6:0] DIV64_M1  = 7'h3F;
    localparam logic [6:0] DIV128_M1 = 7'h7F;
    localparam logic [7:0] VEC_DONE   = 8'h02;
    localparam logic [7:0] VEC_BUFFER = 8'h04;
    localparam int FIFO_W = 1;
    localparam int FIFO_D = 16;
endpackage

// *** hw/btm_fifo.sv ***
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes:   read data comes from a register
`timescale 1ns/1ps
`default_nettype none
module btm_fifo #(
    parameter int WIDTH = btm_pkg::FIFO_W,
    parameter int DEPTH = btm_pkg::FIFO_D
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
        $error("btm_fifo: bad width or depth");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp;
    logic [AW:0]      rp;
    logic [AW:0]      next_wp;
    logic [AW:0]      next_rp;
    logic [WIDTH-1:0] next_out;
    logic             next_ov;
    logic             stored;
    logic [AW:0]      level;
    logic             pop;
    always_comb begin
        stored   = (wp != rp);
        // output register counts toward the depth
        level    = (wp - rp) + {{AW{1'b0}}, out_valid};
        in_ready = (level != (AW+1)'(DEPTH));
        pop      = stored && (!out_valid || out_ready);
        next_wp  = (in_valid && in_ready) ? wp + 1'b1 : wp;
        next_rp  = pop ? rp + 1'b1 : rp;
        next_out = pop ? mem[rp[AW-1:0]] : out_data;
        next_ov  = pop ? 1'b1 : (out_ready ? 1'b0 : out_valid);
    end
    always_ff @(posedge core_clk) begin
        if (in_valid && in_ready) begin
            mem[wp[AW-1:0]] <= in_data;
        end
        if (!rstn) begin
            wp        <= '0;
            rp        <= '0;
            out_data  <= '0;
            out_valid <= 1'b0;
        end else begin
            wp        <= next_wp;
            rp        <= next_rp;
            out_data  <= next_out;
            out_valid <= next_ov;
        end
    end
endmodule
`default_nettype wire

// *** hw/btm_timer.sv ***
// Purpose: bit timer modulator: transmit keying, edge timestamp, generic timer
// Assumes: processor port synchronous to core_clk; edge pin already synchronous
// Notes:   timer ticks on a divided processor clock enable
// Summary of operation
// - count value is 8 low bits plus control bits 7:6 as top bits.
// - each sent mark or space lasts count value plus one processor clocks.
// - mode field: 00 off, 01 generic, 10 receive, 11 transmit.
// - with irq enable, each flag raises its own interrupt, vectors 0x04 and 0x02.
// - transmit/generic: done flag when buffer empty and counter at zero; never when off.
// - receive: done flag set on any edge of the edge input pin.
// - reading the control register clears both flags.
// - transmit: data bit is a one-bit buffer written by processor, taken by timer.
// - transmit: buffer flag set when timer takes the bit; interrupt if enabled.
// - receive: data bit loads 1 for rising edge, 0 for falling edge.
// - receive: count shows processor clocks since previous edge, unless overflowed.
// - receive: buffer flag set when the interval counter overflows.
// - processor clock is crystal clock divided by 16, 32, 64 or 128.
`timescale 1ns/1ps
`default_nettype none
module btm_timer #(
    parameter int CNT_WIDTH = btm_pkg::CNT_W
) (
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic [1:0] clock_divide_select,
    input  wire logic       edge_input_pin,
    output logic            carrier_key,
    output logic            done_irq,
    output logic            buffer_vector_irq,
    output logic      [7:0] irq_vector
);
    if (CNT_WIDTH != btm_pkg::CNT_W) begin : g_bad_width
        $error("btm_timer: count width must be 10");
    end

    ////////////////////////////////////////////////////////////////////////
    // processor clock enable from the crystal clock
    logic [6:0] div_cnt;
    logic [6:0] next_div_cnt;
    logic [6:0] div_top;
    logic       tick;
    always_comb begin
        unique case (clock_divide_select)
            2'h3: div_top = btm_pkg::DIV16_M1;
            2'h2: div_top = btm_pkg::DIV32_M1;
            2'h1: div_top = btm_pkg::DIV64_M1;
            2'h0: div_top = btm_pkg::DIV128_M1;
        endcase
        tick         = (div_cnt >= div_top);
        next_div_cnt = tick ? 7'h00 : div_cnt + 7'h01;
    end
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            div_cnt <= 7'h00;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit bit fifo between the data bit buffer and the keyer
    logic data_bit;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    btm_fifo #(
        .WIDTH (btm_pkg::FIFO_W),
        .DEPTH (btm_pkg::FIFO_D)
    ) u_fifo (
        .core_clk  (core_clk),
        .rstn      (rstn),
        .in_data   (data_bit),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready)
    );

    ////////////////////////////////////////////////////////////////////////
    // registers and timer state
    typedef enum logic [1:0] {
        BTM_IDLE = 2'b00,
        BTM_RUN  = 2'b01,
        BTM_DONE = 2'b11
    } btm_state_e;

    logic [7:0]           count_low;
    logic [1:0]           count_high;
    logic [1:0]           mode;
    logic                 irq_enable;
    logic                 done_or_edge_flag;
    logic                 buffer_full;
    logic                 buffer_empty_or_overflow_flag;
    logic [CNT_WIDTH-1:0] counter;
    logic                 pin_last;
    btm_state_e           state;

    logic [7:0]           next_count_low;
    logic [1:0]           next_count_high;
    logic [1:0]           next_mode;
    logic                 next_irq_enable;
    logic                 next_done;
    logic                 next_data_bit;
    logic                 next_buffer_full;
    logic                 next_bufov;
    logic [CNT_WIDTH-1:0] next_counter;
    logic                 next_pin_last;
    logic                 next_key;
    btm_state_e           next_state;

    logic [CNT_WIDTH-1:0] count_value;
    logic                 wr_low;
    logic                 wr_ctl;
    logic                 rd_ctl;
    logic                 set_done;
    logic                 set_bufov;
    logic                 edge_seen;
    logic                 take;

    function automatic logic hits(input logic [7:0] a, input logic [7:0] want);
        hits = (a == want);
    endfunction

    always_comb begin
        count_value = {count_high, count_low};
        wr_low      = reg_wr && hits(reg_addr, btm_pkg::ADDR_COUNT_LOW);
        wr_ctl      = reg_wr && hits(reg_addr, btm_pkg::ADDR_CONTROL);
        rd_ctl      = reg_rd && hits(reg_addr, btm_pkg::ADDR_CONTROL);
        edge_seen   = (edge_input_pin != pin_last);

        next_count_low   = wr_low ? reg_wdata : count_low;
        next_count_high  = wr_ctl ? reg_wdata[btm_pkg::BIT_CHI:btm_pkg::BIT_CLO] : count_high;
        next_mode        = wr_ctl ? reg_wdata[btm_pkg::BIT_MODE_HI:btm_pkg::BIT_MODE_LO] : mode;
        next_irq_enable  = wr_ctl ? reg_wdata[btm_pkg::BIT_IE] : irq_enable;
        next_data_bit    = data_bit;
        next_buffer_full = buffer_full;
        next_counter     = counter;
        next_pin_last    = edge_input_pin;
        next_key         = carrier_key;
        next_state       = state;
        set_done         = 1'b0;
        set_bufov        = 1'b0;
        take             = 1'b0;
        fifo_out_ready   = 1'b0;

        if (wr_ctl) begin
            next_data_bit    = reg_wdata[btm_pkg::BIT_DATA];
            next_buffer_full = (next_mode == btm_pkg::MODE_TX);
        end
        // buffer moves into the fifo; full fifo holds the buffer
        fifo_in_valid = buffer_full && (mode == btm_pkg::MODE_TX) && !wr_ctl;
        if (fifo_in_valid && fifo_in_ready) begin
            next_buffer_full = 1'b0;
            take             = 1'b1;
        end

        unique case (mode)
            btm_pkg::MODE_OFF: begin
                next_state = BTM_IDLE;
                next_key   = 1'b0;
            end
            btm_pkg::MODE_GEN: begin
                if (tick) begin
                    if (state != BTM_RUN) begin
                        next_counter = count_value;
                        next_state   = BTM_RUN;
                    end else if (counter == '0) begin
                        set_done   = 1'b1;
                        next_state = BTM_DONE;
                    end else begin
                        next_counter = counter - 1'b1;
                    end
                end
            end
            btm_pkg::MODE_RX: begin
                next_state = BTM_IDLE;
                if (tick) begin
                    if (counter == '1) begin
                        set_bufov = 1'b1;
                    end
                    next_counter = counter + 1'b1;
                end
                if (edge_seen) begin
                    set_done = 1'b1;
                    next_data_bit = edge_input_pin;
                    {next_count_high, next_count_low} = counter;
                    // a tick on the edge cycle opens the new interval
                    next_counter = CNT_WIDTH'(tick);
                end
            end
            btm_pkg::MODE_TX: begin
                if (tick) begin
                    if (state == BTM_RUN && counter != '0) begin
                        next_counter = counter - 1'b1;
                    end else if (fifo_out_valid) begin
                        fifo_out_ready = 1'b1;
                        next_key       = fifo_out_data;
                        next_counter   = count_value;
                        next_state     = BTM_RUN;
                    end else if (state == BTM_RUN && !buffer_full) begin
                        set_done   = 1'b1;
                        next_state = BTM_DONE;
                    end
                end
            end
        endcase

        if (take) begin
            set_bufov = 1'b1;
        end
        next_done  = set_done || (done_or_edge_flag && !rd_ctl);
        next_bufov = set_bufov || (buffer_empty_or_overflow_flag && !rd_ctl);
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            count_low                     <= btm_pkg::RESET_COUNT;
            count_high                    <= 2'h0;
            mode                          <= btm_pkg::MODE_OFF;
            irq_enable                    <= 1'b0;
            done_or_edge_flag             <= 1'b0;
            data_bit                      <= 1'b0;
            buffer_full                   <= 1'b0;
            buffer_empty_or_overflow_flag <= 1'b0;
            counter                       <= '0;
            pin_last                      <= 1'b0;
            carrier_key                   <= 1'b0;
            state                         <= BTM_IDLE;
        end else begin
            count_low                     <= next_count_low;
            count_high                    <= next_count_high;
            mode                          <= next_mode;
            irq_enable                    <= next_irq_enable;
            done_or_edge_flag             <= next_done;
            data_bit                      <= next_data_bit;
            buffer_full                   <= next_buffer_full;
            buffer_empty_or_overflow_flag <= next_bufov;
            counter                       <= next_counter;
            pin_last                      <= next_pin_last;
            carrier_key                   <= next_key;
            state                         <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data and interrupt requests
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd && hits(reg_addr, btm_pkg::ADDR_COUNT_LOW)) begin
            next_rdata = count_low;
        end else if (rd_ctl) begin
            next_rdata = {count_high, mode, irq_enable, done_or_edge_flag,
                          data_bit, buffer_empty_or_overflow_flag};
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata <= btm_pkg::RESET_CONTROL;
        end else begin
            reg_rdata <= next_rdata;
        end
    end
    always_comb begin
        done_irq          = irq_enable && done_or_edge_flag;
        buffer_vector_irq = irq_enable && buffer_empty_or_overflow_flag;
        irq_vector        = done_irq ? btm_pkg::VEC_DONE :
                            (buffer_vector_irq ? btm_pkg::VEC_BUFFER : 8'h00);
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_clear_on_read;
        @(posedge core_clk) disable iff (!rstn)
        rd_ctl && !set_done |=> !done_or_edge_flag;
    endproperty
    a_clear_on_read: assert property (p_clear_on_read) else $error("done flag not cleared by read");
    property p_edge_flag;
        @(posedge core_clk) disable iff (!rstn)
        mode == btm_pkg::MODE_RX && edge_seen |=> done_or_edge_flag && data_bit == $past(edge_input_pin);
    endproperty
    a_edge_flag: assert property (p_edge_flag) else $error("edge not captured");
    property p_off_no_done;
        @(posedge core_clk) disable iff (!rstn)
        mode == btm_pkg::MODE_OFF && !done_or_edge_flag |=> !done_or_edge_flag;
    endproperty
    a_off_no_done: assert property (p_off_no_done) else $error("done flag in off mode");
    property p_irq_gate;
        @(posedge core_clk) disable iff (!rstn)
        buffer_vector_irq |-> irq_enable && buffer_empty_or_overflow_flag;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("buffer irq ungated");
    property p_take_flag;
        @(posedge core_clk) disable iff (!rstn)
        take |=> buffer_empty_or_overflow_flag;
    endproperty
    a_take_flag: assert property (p_take_flag) else $error("take did not flag");
    property p_interval;
        @(posedge core_clk) disable iff (!rstn)
        mode == btm_pkg::MODE_RX && edge_seen |=> {count_high, count_low} == $past(counter);
    endproperty
    a_interval: assert property (p_interval) else $error("interval not latched");
endmodule
`default_nettype wire

// *** dv/btm_far_end.sv ***
// Purpose: far side of the bit timer: edge source and keying path
// Assumes: edge level requested by the bench on rising edges
// Notes:   measures each keying segment in core_clk cycles
`timescale 1ns/1ps
`default_nettype none
module btm_far_end (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        carrier_key,
    input  wire logic        edge_lvl,
    output logic             edge_input_pin,
    output logic      [15:0] seg_width,
    output logic      [7:0]  seg_count
);
    logic        key_last;
    logic [15:0] run_len;

    ////////////////////////////////////////////////////////////////
    // segment length of the keying output
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            edge_input_pin <= 1'b0;
            key_last       <= 1'b0;
            run_len        <= 16'h0001;
            seg_width      <= 16'h0000;
            seg_count      <= 8'h00;
        end else begin
            edge_input_pin <= edge_lvl;
            key_last       <= carrier_key;
            if (carrier_key !== key_last) begin
                seg_width <= run_len;
                seg_count <= seg_count + 8'h01;
                run_len   <= 16'h0001;
            end else begin
                run_len <= run_len + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: self-checking bench for the bit timer and its fifo
// Assumes: processor port driven by the bench on rising edges
// Notes:   keying widths come from the far-end model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic [1:0]  clock_divide_select = 2'h3;
    logic        edge_input_pin;
    logic        edge_lvl = 1'b0;
    logic        carrier_key;
    logic        done_irq;
    logic        buffer_vector_irq;
    logic [7:0]  irq_vector;
    logic [15:0] seg_width;
    logic [7:0]  seg_count;
    int          bad_count = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          ext_count = 0;
    localparam logic [7:0] A_CNT = btm_pkg::ADDR_COUNT_LOW;
    localparam logic [7:0] A_CTL = btm_pkg::ADDR_CONTROL;

    btm_timer dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .clock_divide_select(clock_divide_select), .edge_input_pin(edge_input_pin),
        .carrier_key(carrier_key), .done_irq(done_irq), .buffer_vector_irq(buffer_vector_irq),
        .irq_vector(irq_vector));
    btm_far_end far (.core_clk(core_clk), .rstn(rstn), .carrier_key(carrier_key), .edge_lvl(edge_lvl),
        .edge_input_pin(edge_input_pin), .seg_width(seg_width), .seg_count(seg_count));

    initial begin
        forever #2 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic wait_irq(input logic sel_buf, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge core_clk);
            #1;
            if ((sel_buf ? buffer_vector_irq : done_irq) === 1'b1) break;
        end
    endtask

    task automatic wait_seg(input logic [7:0] tgt);
        for (int i = 0; i < 8000 && seg_count !== tgt; i++) begin
            @(posedge core_clk);
            #1;
        end
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] d;
        rd(A_CNT, d);   `CHK("count_rst", 8'h00, d)
        rd(A_CTL, d);   `CHK("ctl_rst", 8'h00, d)
        wr(A_CNT, 8'hA5);
        wr(A_CTL, 8'hC0);
        rd(A_CNT, d);   `CHK("count_low", 8'hA5, d)
        rd(A_CTL, d);   `CHK("count_high", 8'hC0, d)
        wr(8'h22, 8'hFF);
        rd(8'h22, d);   `CHK("unmapped", 8'h00, d)
        wr(A_CTL, 8'h00);
    endtask

    task automatic t_tx(input logic [1:0] sel, input int div);
        logic [7:0] d;
        logic [7:0] s0;
        logic [3:0] bits;
        bits = 4'b0101;
        @(posedge core_clk);
        clock_divide_select <= sel;
        wr(A_CNT, 8'h03);
        s0 = seg_count;
        for (int k = 0; k < 4; k++) wr(A_CTL, {2'b00, btm_pkg::MODE_TX, 2'b10, bits[k], 1'b0});
        rd(A_CTL, d);   `CHK("buf_flag", 1'b1, d[0])
        for (int k = 1; k <= 4; k++) begin
            wait_seg(s0 + 8'(k));
            `CHK("key", bits[k-1], carrier_key)
            if (k > 1) `CHK("width", 16'(4 * div), seg_width)
        end
        wait_irq(1'b0, 2000);
        `CHK("tx_done", 1'b1, done_irq)
        `CHK("vec_done", btm_pkg::VEC_DONE, irq_vector)
        rd(A_CTL, d);   `CHK("f2_set", 1'b1, d[2])
        rd(A_CTL, d);   `CHK("f2_clr", 2'b00, {d[2], d[0]})
        wr(A_CTL, 8'h00);
    endtask

    task automatic t_gen();
        logic [7:0] d;
        logic       keybad;
        keybad = 1'b0;
        clock_divide_select <= 2'h3;
        wr(A_CNT, 8'h02);
        wr(A_CTL, {2'b00, btm_pkg::MODE_GEN, 4'h8});
        for (int i = 0; i < 300 && done_irq !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
            if (carrier_key !== 1'b0) keybad = 1'b1;
        end
        `CHK("gen_done", 1'b1, done_irq)
        `CHK("gen_pin", 1'b0, keybad)
        wr(A_CTL, {2'b00, btm_pkg::MODE_OFF, 4'h8});
        rd(A_CTL, d);
        repeat (300) @(posedge core_clk);
        #1 `CHK("off_done", 1'b0, done_irq)
        rd(A_CTL, d);   `CHK("off_f2", 1'b0, d[2])
    endtask

    task automatic t_rx();
        logic [7:0] d;
        logic [7:0] c;
        wr(A_CTL, {2'b00, btm_pkg::MODE_RX, 4'h0});
        edge_lvl <= 1'b1;
        repeat (160) @(posedge core_clk);
        edge_lvl <= 1'b0;
        repeat (20) @(posedge core_clk);
        rd(A_CNT, d);
        rd(A_CTL, c);
        `CHK("interval", 10'd10, {c[7:6], d})
        `CHK("edge_f2", 1'b1, c[2])
        `CHK("fall_bit", 1'b0, c[1])
        @(posedge core_clk);
        edge_lvl <= 1'b1;
        repeat (20) @(posedge core_clk);
        rd(A_CTL, c);
        `CHK("rise_bit", 2'b11, c[2:1])
        wr(A_CTL, {2'b00, btm_pkg::MODE_RX, 4'h8});
        wait_irq(1'b1, 20000);
        `CHK("ovf_irq", 1'b1, buffer_vector_irq)
        `CHK("vec_buf", btm_pkg::VEC_BUFFER, irq_vector)
        rd(A_CTL, c);
        if (c[0] === 1'b1) ext_count++;
        `CHK("ovf_ext", 1, ext_count)
        #1 `CHK("ovf_clr", 1'b0, buffer_vector_irq)
        wr(A_CTL, 8'h00);
    endtask

    task automatic t_fifo();
        logic [7:0] d;
        logic [7:0] s0;
        int         n;
        n = 0;
        @(posedge core_clk);
        clock_divide_select <= 2'h3;
        wr(A_CNT, 8'hFF);
        s0 = seg_count;
        // long first bit keeps the keyer busy while the queue fills
        wr(A_CTL, {2'b00, btm_pkg::MODE_TX, 3'b001, 1'b0});
        wait_seg(s0 + 8'h01);
        for (int i = 1; i < 20; i++) begin
            wr(A_CTL, {2'b00, btm_pkg::MODE_TX, 2'b00, ~i[0], 1'b0});
            rd(A_CTL, d);
            if (d[0] !== 1'b1) break;
            n++;
        end
        `CHK("fifo_fill", btm_pkg::FIFO_D, n)
        wr(A_CNT, 8'h00);
        for (int k = 2; k <= btm_pkg::FIFO_D + 2; k++) begin
            wait_seg(s0 + 8'(k));
            `CHK("fifo_data", k[0], carrier_key)
            `CHK("fifo_width", 16'(k == 2 ? 256 * 16 : 16), seg_width)
        end
        repeat (40) @(posedge core_clk);
        rd(A_CTL, d);
        `CHK("fifo_empty", 2'b11, {d[2], d[0]})
        wr(A_CTL, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        t_regs();
        t_tx(2'b11, 16);
        t_tx(2'b00, 128);
        t_gen();
        t_rx();
        t_fifo();
        end_sim();
    end
endmodule
`default_nettype wire
